// ---- shared/comparator_pkg.sv ----
`default_nettype none
package comparator_pkg;

  // ==========================================
  // register addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h9B;
  localparam logic [7:0] ADDR_MODE    = 8'h9D;
  localparam logic [7:0] ADDR_MUX     = 8'h9F;

  // ==========================================
  // reset values
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_MODE    = 8'h02;
  localparam logic [7:0] RESET_MUX     = 8'hFF;

  // ==========================================
  // field positions
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_OUT_BIT    = 6;
  localparam int CTL_RISE_BIT   = 5;
  localparam int CTL_FALL_BIT   = 4;
  localparam int CTL_HYP_LSB    = 2;
  localparam int CTL_HYN_LSB    = 0;
  localparam int MODE_RISE_BIT  = 5;
  localparam int MODE_FALL_BIT  = 4;
  localparam int MODE_RESP_LSB  = 0;
  localparam int NIB_OFF_BIT    = 3;
  localparam int NEG_LSB        = 4;
  localparam int POS_LSB        = 0;
  localparam logic [7:0] MODE_WRITE_MASK = 8'h33;
  localparam logic [7:0] CTL_WRITE_MASK  = 8'hBF;

  // ==========================================
  // types
  typedef enum logic [1:0] {
    RESP_100NS  = 2'b00,
    RESP_175NS  = 2'b01,
    RESP_320NS  = 2'b10,
    RESP_1050NS = 2'b11
  } resp_code_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // onehot bit k selects the k-th pin of the list; all zero means none
  typedef struct packed {
    logic       power_on;
    logic [7:0] neg_onehot;
    logic [7:0] pos_onehot;
    resp_code_t response;
    logic [1:0] hyst_pos;
    logic [1:0] hyst_neg;
  } analog_ctrl_t;

endpackage
`default_nettype wire

// ---- hdl/comparator_control_regs.sv ----
`timescale 1ns/100ps
`default_nettype none

// How it works
// RULE_01 - upper mux nibble picks negative odd pin
// RULE_02 - lower mux nibble picks positive even pin
// RULE_03 - nibble top bit set disconnects input
// RULE_04 - mux register at 0x9F, resets all ones
// RULE_05 - mode bits 7-6, 3-2 read zero
// RULE_06 - mode bit5 enables rising-edge interrupt
// RULE_07 - mode bit4 enables falling-edge interrupt
// RULE_08 - mode bits 1-0 drive response time
// RULE_09 - mode register at 0x9D, resets 0x02
// RULE_10 - sticky edge flags until software clears
// RULE_11 - interrupt when enabled flag is set
// RULE_12 - enable powers comparator; off drives output low
// RULE_13 - software clears flags after power or mode change
// RULE_14 - two-flop sync before edge detection
// RULE_15 - edge set beats simultaneous software clear
module comparator_control_regs
  import comparator_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire sfr_req_t     sfr,
  output var  logic [7:0]   sfr_rdata,
  input  wire logic         async_comparator_output,
  output var  analog_ctrl_t analog,
  output var  logic         sync_comparator_output,
  output var  logic         comparator_irq
);

  // ==========================================
  // decode helpers
  function automatic logic [7:0] pin_onehot(input logic [3:0] nib);
    logic [7:0] sel;
    sel = 8'h00;
    if (!nib[NIB_OFF_BIT]) begin
      sel[nib[2:0]] = 1'b1;
    end
    return sel;
  endfunction

  function automatic logic addr_hit(input sfr_req_t r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  // ==========================================
  // registers
  logic [7:0] comparator_control;
  logic [7:0] comparator_mode_select;
  logic [7:0] comparator_input_mux;
  logic       sync_a;
  logic       sync_b;
  logic       sync_prev;

  wire logic wr_control = sfr.wr && addr_hit(sfr, ADDR_CONTROL);
  wire logic wr_mode    = sfr.wr && addr_hit(sfr, ADDR_MODE);
  wire logic wr_mux     = sfr.wr && addr_hit(sfr, ADDR_MUX);

  wire logic comparator_enable = comparator_control[CTL_ENABLE_BIT];
  wire logic rise_edge_flag    = comparator_control[CTL_RISE_BIT];
  wire logic fall_edge_flag    = comparator_control[CTL_FALL_BIT];
  wire logic rise_irq_enable   = comparator_mode_select[MODE_RISE_BIT];
  wire logic fall_irq_enable   = comparator_mode_select[MODE_FALL_BIT];

  // ==========================================
  // synchroniser and edge detect
  // edges only count while powered: the analog output is meaningless when off
  wire logic rise_edge = comparator_enable && sync_b && !sync_prev;
  wire logic fall_edge = comparator_enable && !sync_b && sync_prev;
  // nothing but sync_b reads sync_a: the first stage may still be settling

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_a    <= 1'b0;
      sync_b    <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      sync_a    <= async_comparator_output; // RULE_14
      sync_b    <= sync_a; // RULE_14
      sync_prev <= sync_b;
    end
  end

  // ==========================================
  // next register values
  wire logic [7:0] ctl_written =
    (sfr.wdata & CTL_WRITE_MASK) | (comparator_control & ~CTL_WRITE_MASK);
  wire logic [7:0] ctl_base = wr_control ? ctl_written : comparator_control;

  // hardware set is or-ed last so a same-cycle clear cannot lose it
  wire logic next_rise = ctl_base[CTL_RISE_BIT] | rise_edge; // RULE_10 RULE_15
  wire logic next_fall = ctl_base[CTL_FALL_BIT] | fall_edge; // RULE_10 RULE_15

  wire logic [7:0] next_control = {
    ctl_base[CTL_ENABLE_BIT],
    1'b0,
    next_rise,
    next_fall,
    ctl_base[3:0]
  };

  wire logic [7:0] next_mode =
    wr_mode ? (sfr.wdata & MODE_WRITE_MASK) : comparator_mode_select; // RULE_05

  wire logic [7:0] next_mux = wr_mux ? sfr.wdata : comparator_input_mux; // RULE_04

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      comparator_control     <= RESET_CONTROL;
      comparator_mode_select <= RESET_MODE; // RULE_09
      comparator_input_mux   <= RESET_MUX; // RULE_04
    end else begin
      comparator_control     <= next_control;
      comparator_mode_select <= next_mode;
      comparator_input_mux   <= next_mux;
    end
  end

  // ==========================================
  // read path
  // output state bit shows the live synchronised comparator level
  wire logic [7:0] control_view = {
    comparator_control[CTL_ENABLE_BIT],
    sync_b,
    comparator_control[5:0]
  };

  wire logic [7:0] read_value =
    addr_hit(sfr, ADDR_CONTROL) ? control_view :
    addr_hit(sfr, ADDR_MODE)    ? comparator_mode_select :
    addr_hit(sfr, ADDR_MUX)     ? comparator_input_mux :
                                  8'h00;

  wire logic [7:0] next_rdata = sfr.rd ? read_value : sfr_rdata;

  // ==========================================
  // analog side and outputs
  wire analog_ctrl_t next_analog = '{
    power_on:   comparator_enable, // RULE_12
    neg_onehot: pin_onehot(comparator_input_mux[NEG_LSB +: 4]), // RULE_01 RULE_03
    pos_onehot: pin_onehot(comparator_input_mux[POS_LSB +: 4]), // RULE_02 RULE_03
    response:   resp_code_t'(comparator_mode_select[MODE_RESP_LSB +: 2]), // RULE_08
    hyst_pos:   comparator_control[CTL_HYP_LSB +: 2],
    hyst_neg:   comparator_control[CTL_HYN_LSB +: 2]
  };

  wire logic next_irq =
    (rise_edge_flag && rise_irq_enable) || // RULE_06 RULE_11
    (fall_edge_flag && fall_irq_enable); // RULE_07 RULE_11

  wire logic next_sync_out = comparator_enable && sync_b; // RULE_12

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sfr_rdata              <= 8'h00;
      analog                 <= '0;
      sync_comparator_output <= 1'b0;
      comparator_irq         <= 1'b0;
    end else begin
      sfr_rdata              <= next_rdata;
      analog                 <= next_analog;
      sync_comparator_output <= next_sync_out;
      comparator_irq         <= next_irq;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_neg_select_map: assert property ( // RULE_01
    !comparator_input_mux[7] |=>
      analog.neg_onehot == (8'h01 << $past(comparator_input_mux[6:4])))
    else $error("negative input select wrong");

  chk_pos_select_map: assert property ( // RULE_02
    !comparator_input_mux[3] |=>
      analog.pos_onehot == (8'h01 << $past(comparator_input_mux[2:0])))
    else $error("positive input select wrong");

  chk_nibble_off: assert property ( // RULE_03
    comparator_input_mux[7] |=> analog.neg_onehot == 8'h00)
    else $error("negative input not disconnected");

  chk_pos_nibble_off: assert property ( // RULE_03
    comparator_input_mux[3] |=> analog.pos_onehot == 8'h00)
    else $error("positive input not disconnected");

  chk_mux_readback: assert property ( // RULE_04
    wr_mux ##1 sfr.rd && addr_hit(sfr, ADDR_MUX) && !sfr.wr |=>
      sfr_rdata == $past(sfr.wdata, 2))
    else $error("mux register readback wrong");

  chk_mode_reserved: assert property ( // RULE_05
    sfr.rd && addr_hit(sfr, ADDR_MODE) |=> sfr_rdata[7:6] == 2'b00
      && sfr_rdata[3:2] == 2'b00)
    else $error("mode reserved bits not zero");

  chk_rise_enable: assert property ( // RULE_06
    rise_edge_flag && !fall_edge_flag && !rise_irq_enable |=> !comparator_irq)
    else $error("rise interrupt not masked");

  chk_fall_enable: assert property ( // RULE_07
    fall_edge_flag && !rise_edge_flag && !fall_irq_enable |=> !comparator_irq)
    else $error("fall interrupt not masked");

  chk_response_code: assert property ( // RULE_08
    wr_mode |=> ##1 analog.response == $past(sfr.wdata[1:0], 2))
    else $error("response code not driven");

  chk_rise_flag_sticky: assert property ( // RULE_10
    rise_edge_flag && !wr_control |=> rise_edge_flag)
    else $error("rise flag dropped without clear");

  chk_edge_sets_flag: assert property ( // RULE_10
    $rose(sync_b) && comparator_enable |=> rise_edge_flag)
    else $error("rising edge not flagged");

  chk_irq_request: assert property ( // RULE_11
    (rise_edge_flag && rise_irq_enable) || (fall_edge_flag && fall_irq_enable)
      |=> comparator_irq)
    else $error("interrupt not requested");

  chk_disabled_low: assert property ( // RULE_12
    !comparator_enable |=> !sync_comparator_output && !analog.power_on)
    else $error("disabled comparator output not low");

  chk_sync_depth: assert property ( // RULE_14
    $rose(async_comparator_output) && comparator_enable ##1 comparator_enable
      |-> !rise_edge)
    else $error("edge detected before two sync stages");

  chk_set_wins: assert property ( // RULE_15
    wr_control && !sfr.wdata[CTL_FALL_BIT] && fall_edge |=> fall_edge_flag)
    else $error("edge lost to software clear");

  // ==========================================
  // reset, hold, flag, readback, interrupt and output checks
  // disable iff hides reset itself, so look at the first edge after it
  chk_mux_reset: assert property ( // RULE_04
    $fell(rst) |-> comparator_input_mux == RESET_MUX)
    else $error("mux register reset value wrong");

  chk_mode_reset: assert property ( // RULE_09
    $fell(rst) |-> comparator_mode_select == RESET_MODE)
    else $error("mode register reset value wrong");

  chk_mux_hold: assert property ( // RULE_04
    !wr_mux |=> $stable(comparator_input_mux))
    else $error("mux register changed without write");

  chk_mode_hold: assert property ( // RULE_08
    !wr_mode |=> $stable(comparator_mode_select))
    else $error("mode register changed without write");

  chk_mode_reserved_state: assert property ( // RULE_05
    (comparator_mode_select & ~MODE_WRITE_MASK) == 8'h00)
    else $error("mode reserved bits stored");

  chk_mode_readback: assert property ( // RULE_05
    sfr.rd && addr_hit(sfr, ADDR_MODE) |=> sfr_rdata == $past(comparator_mode_select))
    else $error("mode register readback wrong");

  chk_fall_flag_sticky: assert property ( // RULE_10
    fall_edge_flag && !wr_control |=> fall_edge_flag)
    else $error("fall flag dropped without clear");

  chk_fall_sets_flag: assert property ( // RULE_10
    $fell(sync_b) && comparator_enable |=> fall_edge_flag)
    else $error("falling edge not flagged");

  chk_rise_clear: assert property ( // RULE_10
    wr_control && !sfr.wdata[CTL_RISE_BIT] && !rise_edge |=> !rise_edge_flag)
    else $error("rise flag not cleared by write");

  chk_fall_clear: assert property ( // RULE_10
    wr_control && !sfr.wdata[CTL_FALL_BIT] && !fall_edge |=> !fall_edge_flag)
    else $error("fall flag not cleared by write");

  // a clear write cannot hide an edge on either flag
  chk_rise_set_wins: assert property ( // RULE_15
    wr_control && !sfr.wdata[CTL_RISE_BIT] && rise_edge |=> rise_edge_flag)
    else $error("rising edge lost to software clear");

  chk_irq_idle: assert property ( // RULE_11
    !((rise_edge_flag && rise_irq_enable) || (fall_edge_flag && fall_irq_enable))
      |=> !comparator_irq)
    else $error("interrupt without enabled flag");

  chk_sync_out_level: assert property ( // RULE_12
    comparator_enable |=> sync_comparator_output == $past(sync_b))
    else $error("synchronised output does not follow comparator");

  chk_power_follows: assert property ( // RULE_12
    comparator_enable |=> analog.power_on)
    else $error("enabled comparator not powered");

endmodule
`default_nettype wire

// ---- dv/comparator_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// analog comparator stand-in
module comparator_model
  import comparator_pkg::*;
(
  input  wire logic         level,
  input  wire analog_ctrl_t analog,
  output var  logic         raw_out
);
  function automatic int settle_ns(input resp_code_t code);
    case (code)
      RESP_100NS: return 100;
      RESP_175NS: return 175;
      RESP_320NS: return 320;
      default:    return 1050;
    endcase
  endfunction

  // slower codes settle later; unpowered output sits low
  initial begin
    raw_out = 1'b0;
    forever begin
      @(level, analog.power_on);
      raw_out <= #(settle_ns(analog.response)) analog.power_on & level;
    end
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// register and edge-flag bench
module testbench;
  import comparator_pkg::*;
  logic         mclk;
  logic         rst;
  logic         level;
  logic         raw;
  logic         sync_out;
  logic         irq;
  logic [7:0]   rdata;
  logic [7:0]   v;
  logic [7:0]   m;
  sfr_req_t     sfr;
  analog_ctrl_t analog;
  int           fails;
  int           n_checks;
  int           i;

  comparator_control_regs u_dut (
    .mclk                    (mclk),
    .rst                     (rst),
    .sfr                     (sfr),
    .sfr_rdata               (rdata),
    .async_comparator_output (raw),
    .analog                  (analog),
    .sync_comparator_output  (sync_out),
    .comparator_irq          (irq)
  );
  comparator_model u_model (.level(level), .analog(analog), .raw_out(raw));

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    sfr.wr = 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk);
    sfr.rd = 1'b0;
    d = rdata;
  endtask

  // write then read the same register on the very next edge
  task automatic sfr_wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk);
    sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk);
    sfr.rd = 1'b0;
    q = rdata;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // irq level must appear within 200 clocks, well above the slowest settle time plus sync
  task automatic wait_irq(input logic want);
    int k;
    for (k = 0; k < 200 && irq !== want; k++) @(negedge mclk);
    check({7'h00, irq}, {7'h00, want});
    if (irq !== want) close_out();
  endtask

  function automatic logic [7:0] sel_exp(input logic [3:0] nib);
    return nib[3] ? 8'h00 : (8'h01 << nib[2:0]);
  endfunction

  initial begin
    rst = 1'b1;
    level = 1'b0;
    sfr = '0;
    fails = 0;
    n_checks = 0;
    void'($urandom(53359));
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    check({6'h00, analog.response}, 8'h02);
    check(analog.neg_onehot | analog.pos_onehot, 8'h00);
    sfr_rd(8'h9D, v);
    check(v, 8'h02);
    sfr_rd(8'h9F, v);
    check(v, 8'hFF);
    $display("test reset done");
    for (i = 0; i < 24; i++) begin
      m = (i < 16) ? {i[3:0], 4'hF - i[3:0]} : 8'($urandom);
      sfr_wr_rd(8'h9F, m, v);
      check(analog.neg_onehot, sel_exp(m[7:4]));
      check(analog.pos_onehot, sel_exp(m[3:0]));
      check(v, m);
    end
    $display("test mux done");
    for (i = 0; i < 8; i++) begin
      m = (i < 4) ? (8'hFC | 8'(i)) : 8'($urandom);
      sfr_wr(8'h9D, m);
      repeat (2) @(negedge mclk);
      check({6'h00, analog.response}, {6'h00, m[1:0]});
      sfr_rd(8'h9D, v);
      check(v, m & 8'h33);
    end
    sfr_rd(8'h9C, v);
    check(v, 8'h00);
    $display("test mode done");
    sfr_wr(8'h9B, 8'h80);
    sfr_wr(8'h9D, 8'h20);
    sfr_wr(8'h9B, 8'h80);
    level = 1'b1;
    wait_irq(1'b1);
    sfr_rd(8'h9B, v);
    check(v & 8'h70, 8'h60);
    check({7'h00, sync_out}, 8'h01);
    sfr_wr(8'h9D, 8'h10);
    wait_irq(1'b0);
    level = 1'b0;
    wait_irq(1'b1);
    sfr_rd(8'h9B, v);
    check(v & 8'h70, 8'h30);
    sfr_wr(8'h9B, 8'h80);
    wait_irq(1'b0);
    $display("test edges done");
    sfr_wr(8'h9D, 8'h30);
    level = 1'b1;
    wait_irq(1'b1);
    // clear lands on the very edge at which the synced fall is seen
    level = 1'b0;
    repeat (6) @(negedge mclk);
    sfr_wr(8'h9B, 8'h80);
    sfr_rd(8'h9B, v);
    check(v & 8'h30, 8'h10);
    $display("test set wins done");
    sfr_wr(8'h9B, 8'h80);
    wait_irq(1'b0);
    level = 1'b1;
    wait_irq(1'b1);
    // power off while the synced level is still high
    sfr_wr(8'h9B, 8'h0D);
    @(negedge mclk);
    check({6'h00, sync_out, analog.power_on}, 8'h00);
    check({4'h0, analog.hyst_pos, analog.hyst_neg}, 8'h0D);
    // the model drops its output after power-off: that fall must not be flagged
    repeat (80) @(negedge mclk);
    check({6'h00, irq, sync_out}, 8'h00);
    sfr_rd(8'h9B, v);
    check(v, 8'h0D);
    $display("test disabled done");
    close_out();
  end
endmodule
`default_nettype wire
